/* File: hw/rtcpit_map.svh */
// Register offsets, field positions, reset values and sync timing of the counter block
`ifndef RTCPIT_MAP_SVH
`define RTCPIT_MAP_SVH

`define RTCPIT_OFS_CTRL      5'h00
`define RTCPIT_OFS_STATUS    5'h01
`define RTCPIT_OFS_INTEN     5'h02
`define RTCPIT_OFS_INTFLAG   5'h03
`define RTCPIT_OFS_TEMP      5'h04
`define RTCPIT_OFS_DBG       5'h05
`define RTCPIT_OFS_CLOCK_SOURCE    5'h07
`define RTCPIT_OFS_CNT_L     5'h08
`define RTCPIT_OFS_CNT_H     5'h09
`define RTCPIT_OFS_PER_L     5'h0a
`define RTCPIT_OFS_PER_H     5'h0b
`define RTCPIT_OFS_CMP_L     5'h0c
`define RTCPIT_OFS_CMP_H     5'h0d
`define RTCPIT_OFS_PITCTRL   5'h10
`define RTCPIT_OFS_PITSTAT   5'h11
`define RTCPIT_OFS_PITINTEN  5'h12
`define RTCPIT_OFS_PITFLAG   5'h13
`define RTCPIT_OFS_PITDBG    5'h15

`define RTCPIT_EN_BIT        0
`define RTCPIT_STBY_BIT      7
`define RTCPIT_FIELD_LSB     3
`define RTCPIT_FIELD_MSB     6
`define RTCPIT_OVF_BIT       0
`define RTCPIT_CMP_BIT       1

`define RTCPIT_CTRL_RST      8'h00
`define RTCPIT_CNT_RST       16'h0000
`define RTCPIT_PER_RST       16'h00ff
`define RTCPIT_CMP_RST       16'h0000

`define RTCPIT_SYNC_TICKS    2'h2
`define RTCPIT_1K_HALF       5'h0f

`endif

/* File: hw/rtcpit_pkg.sv */
// Types shared by the counter block and its users
package rtcpit_pkg;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rtcpit_bus_s;

   typedef enum logic [1:0] {
      RTCPIT_SRC_32K = 2'b00,
      RTCPIT_SRC_1K = 2'b01,
      RTCPIT_SRC_RSVD = 2'b10,
      RTCPIT_SRC_EXT = 2'b11
   } rtcpit_clock_source_e;

endpackage

/* File: hw/rtcpit.sv */
// Real-time counter with periodic interrupt timer and register port
`include "rtcpit_map.svh"

module rtcpit #(
   parameter int unsigned PRESC_W = 15
) (
   input wire logic clk,
   input wire logic rstn,
   input wire rtcpit_pkg::rtcpit_bus_s bus,
   output logic [7:0] rdata,
   input wire logic osc_32768_hz,
   input wire logic external_clock_pin,
   input wire logic sleep_standby,
   input wire logic cpu_halted,
   output logic irq_counter,
   output logic irq_periodic
);
   import rtcpit_pkg::*;

   function automatic logic [PRESC_W-1:0] low_mask(input logic [4:0] n);
      logic [PRESC_W-1:0] m;
      m = '0;
      for (int i = 0; i < PRESC_W; i++) begin
         m[i] = (i < int'(n));
      end
      return m;
   endfunction

   logic [7:0] ctrl_sw, ctrl_act, pit_sw, pit_act, temp;
   logic [15:0] cnt, cnt_sw, per_sw, per_act, cmp_sw, cmp_act, next_cnt;
   logic [1:0] int_en, int_flag;
   logic [3:0] busy;
   logic pit_busy, pit_en, pit_flag, dbg_run, pit_dbg_run;
   rtcpit_clock_source_e clk_sel;
   logic [2:0] s32, sext;
   logic [4:0] div1k;
   logic [1:0] sync_cnt;
   logic [PRESC_W-1:0] presc, cnt_mask, pit_mask;
   logic rise32, rise1k, riseext, slow_tick, apply, any_wr_sync;
   logic rtc_run, pit_run, cnt_tick, pit_tick, wrap, match;
   logic wr_ctrl, wr_cnt, wr_per, wr_cmp, wr_pit;

   // Bus decode; 16-bit registers commit on the high byte
   assign wr_ctrl = bus.wr && bus.addr == `RTCPIT_OFS_CTRL;
   assign wr_cnt = bus.wr && bus.addr == `RTCPIT_OFS_CNT_H;
   assign wr_per = bus.wr && bus.addr == `RTCPIT_OFS_PER_H;
   assign wr_cmp = bus.wr && bus.addr == `RTCPIT_OFS_CMP_H;
   assign wr_pit = bus.wr && bus.addr == `RTCPIT_OFS_PITCTRL;
   assign any_wr_sync = wr_ctrl | wr_cnt | wr_per | wr_cmp | wr_pit;

   // Slow clock pins are asynchronous: two flops, then edge detect on stage two
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s32 <= 3'h0;
         sext <= 3'h0;
      end else begin
         s32 <= {s32[1:0], osc_32768_hz};
         sext <= {sext[1:0], external_clock_pin};
      end
   end
   assign rise32 = s32[1] & ~s32[2];
   assign riseext = sext[1] & ~sext[2];

   // 1.024 kHz derived from the 32.768 kHz source by 32
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div1k <= 5'h00;
      end else if (rise32) begin
         div1k <= div1k + 5'h01;
      end
   end
   assign rise1k = rise32 && div1k == `RTCPIT_1K_HALF;

   always_comb begin
      unique case (clk_sel)
         RTCPIT_SRC_32K: slow_tick = rise32;
         RTCPIT_SRC_1K: slow_tick = rise1k;
         RTCPIT_SRC_EXT: slow_tick = riseext;
         default: slow_tick = 1'b0;
      endcase
   end

   // Sync window: a fresh write restarts it, so a pending update is never lost
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_cnt <= 2'h0;
      end else if (any_wr_sync) begin
         sync_cnt <= 2'h0;
      end else if (apply) begin
         sync_cnt <= 2'h0;
      end else if ((|busy | pit_busy) && slow_tick) begin
         sync_cnt <= sync_cnt + 2'h1;
      end
   end
   assign apply = (|busy | pit_busy) && slow_tick && !any_wr_sync
      && sync_cnt == `RTCPIT_SYNC_TICKS - 2'h1;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 4'h0;
         pit_busy <= 1'b0;
      end else begin
         busy[0] <= wr_ctrl | (busy[0] & ~apply);
         busy[1] <= wr_cnt | (busy[1] & ~apply);
         busy[2] <= wr_per | (busy[2] & ~apply);
         busy[3] <= wr_cmp | (busy[3] & ~apply);
         pit_busy <= wr_pit | (pit_busy & ~apply);
      end
   end

   // Software-side copies
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_sw <= `RTCPIT_CTRL_RST;
         pit_sw <= 8'h00;
         cnt_sw <= `RTCPIT_CNT_RST;
         per_sw <= `RTCPIT_PER_RST;
         cmp_sw <= `RTCPIT_CMP_RST;
         int_en <= 2'h0;
         pit_en <= 1'b0;
         dbg_run <= 1'b0;
         pit_dbg_run <= 1'b0;
         clk_sel <= RTCPIT_SRC_32K;
      end else if (bus.wr) begin
         unique case (bus.addr)
            `RTCPIT_OFS_CTRL: ctrl_sw <= {bus.wdata[7:3], 2'h0, bus.wdata[0]};
            `RTCPIT_OFS_PITCTRL: pit_sw <= {1'b0, bus.wdata[6:3], 2'h0, bus.wdata[0]};
            `RTCPIT_OFS_CNT_H: cnt_sw <= {bus.wdata, temp};
            `RTCPIT_OFS_PER_H: per_sw <= {bus.wdata, temp};
            `RTCPIT_OFS_CMP_H: cmp_sw <= {bus.wdata, temp};
            `RTCPIT_OFS_INTEN: int_en <= bus.wdata[1:0];
            `RTCPIT_OFS_PITINTEN: pit_en <= bus.wdata[0];
            `RTCPIT_OFS_DBG: dbg_run <= bus.wdata[0];
            `RTCPIT_OFS_PITDBG: pit_dbg_run <= bus.wdata[0];
            `RTCPIT_OFS_CLOCK_SOURCE: clk_sel <= rtcpit_clock_source_e'(bus.wdata[1:0]);
            default: ;
         endcase
      end
   end

   // Shared byte latch: low-byte writes and reads park the other half here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp <= 8'h00;
      end else if (bus.wr && (bus.addr == `RTCPIT_OFS_TEMP || bus.addr == `RTCPIT_OFS_CNT_L
            || bus.addr == `RTCPIT_OFS_PER_L || bus.addr == `RTCPIT_OFS_CMP_L)) begin
         temp <= bus.wdata;
      end else if (bus.rd) begin
         unique case (bus.addr)
            `RTCPIT_OFS_CNT_L: temp <= cnt[15:8];
            `RTCPIT_OFS_PER_L: temp <= per_sw[15:8];
            `RTCPIT_OFS_CMP_L: temp <= cmp_sw[15:8];
            default: ;
         endcase
      end
   end

   // Values the slow side acts on, moved over only at the end of the window
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_act <= `RTCPIT_CTRL_RST;
         pit_act <= 8'h00;
         per_act <= `RTCPIT_PER_RST;
         cmp_act <= `RTCPIT_CMP_RST;
      end else if (apply) begin
         ctrl_act <= ctrl_sw;
         pit_act <= pit_sw;
         per_act <= per_sw;
         cmp_act <= cmp_sw;
      end
   end

   // Prescaler runs while either function is on, else parked at zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         presc <= '0;
      end else if (!ctrl_act[`RTCPIT_EN_BIT] && !pit_act[`RTCPIT_EN_BIT]) begin
         presc <= '0;
      end else if (slow_tick) begin
         presc <= presc + PRESC_W'(1);
      end
   end

   assign cnt_mask = low_mask(5'(ctrl_act[`RTCPIT_FIELD_MSB:`RTCPIT_FIELD_LSB]));
   assign pit_mask = low_mask(5'(pit_act[`RTCPIT_FIELD_MSB:`RTCPIT_FIELD_LSB]) + 5'h01);
   assign rtc_run = ctrl_act[`RTCPIT_EN_BIT]
      && !(sleep_standby && !ctrl_act[`RTCPIT_STBY_BIT])
      && !(cpu_halted && !dbg_run);
   assign pit_run = pit_act[`RTCPIT_EN_BIT] && !(cpu_halted && !pit_dbg_run);
   assign cnt_tick = slow_tick && rtc_run && (presc & cnt_mask) == cnt_mask;
   assign pit_tick = slow_tick && pit_run
      && pit_act[`RTCPIT_FIELD_MSB:`RTCPIT_FIELD_LSB] != 4'h0
      && (presc & pit_mask) == pit_mask;

   assign next_cnt = (cnt == per_act) ? 16'h0000 : cnt + 16'h0001;
   assign wrap = cnt_tick && cnt == per_act;
   assign match = cnt_tick && next_cnt == cmp_act;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= `RTCPIT_CNT_RST;
      end else if (apply && busy[1]) begin
         cnt <= cnt_sw;
      end else if (cnt_tick) begin
         cnt <= next_cnt;
      end
   end

   // Flags: the event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_flag <= 2'h0;
         pit_flag <= 1'b0;
      end else begin
         int_flag[0] <= wrap | (int_flag[0]
            & ~(bus.wr && bus.addr == `RTCPIT_OFS_INTFLAG && bus.wdata[0]));
         int_flag[1] <= match | (int_flag[1]
            & ~(bus.wr && bus.addr == `RTCPIT_OFS_INTFLAG && bus.wdata[1]));
         pit_flag <= pit_tick | (pit_flag
            & ~(bus.wr && bus.addr == `RTCPIT_OFS_PITFLAG && bus.wdata[0]));
      end
   end

   // Requests follow the registered flags one cycle later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_counter <= 1'b0;
         irq_periodic <= 1'b0;
      end else begin
         irq_counter <= |(int_flag & int_en);
         irq_periodic <= pit_flag & pit_en;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (!bus.rd) begin
         rdata <= 8'h00;
      end else begin
         unique case (bus.addr)
            `RTCPIT_OFS_CTRL: rdata <= ctrl_sw;
            `RTCPIT_OFS_STATUS: rdata <= {4'h0, busy};
            `RTCPIT_OFS_INTEN: rdata <= {6'h00, int_en};
            `RTCPIT_OFS_INTFLAG: rdata <= {6'h00, int_flag};
            `RTCPIT_OFS_TEMP: rdata <= temp;
            `RTCPIT_OFS_DBG: rdata <= {7'h00, dbg_run};
            `RTCPIT_OFS_CLOCK_SOURCE: rdata <= {6'h00, clk_sel};
            `RTCPIT_OFS_CNT_L: rdata <= cnt[7:0];
            `RTCPIT_OFS_PER_L: rdata <= per_sw[7:0];
            `RTCPIT_OFS_CMP_L: rdata <= cmp_sw[7:0];
            `RTCPIT_OFS_CNT_H: rdata <= temp;
            `RTCPIT_OFS_PER_H: rdata <= temp;
            `RTCPIT_OFS_CMP_H: rdata <= temp;
            `RTCPIT_OFS_PITCTRL: rdata <= pit_sw;
            `RTCPIT_OFS_PITSTAT: rdata <= {7'h00, pit_busy};
            `RTCPIT_OFS_PITINTEN: rdata <= {7'h00, pit_en};
            `RTCPIT_OFS_PITFLAG: rdata <= {7'h00, pit_flag};
            `RTCPIT_OFS_PITDBG: rdata <= {7'h00, pit_dbg_run};
            default: rdata <= 8'h00;
         endcase
      end
   end

   // Slow ticks since the last synced write; saturates so a long idle spell never aliases
   logic [1:0] wr_ticks;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ticks <= 2'h0;
      end else if (any_wr_sync) begin
         wr_ticks <= 2'h0;
      end else if (slow_tick && wr_ticks != 2'h3) begin
         wr_ticks <= wr_ticks + 2'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   wrap_flag_a: assert property (wrap |=> int_flag[0]) else $error("overflow flag missing");
   match_flag_a: assert property (match |=> int_flag[1]) else $error("compare flag missing");
   ctr_request_a: assert property (##1 irq_counter == $past(|(int_flag & int_en)))
      else $error("counter request wrong");
   pit_request_a: assert property (##1 irq_periodic == $past(pit_flag & pit_en))
      else $error("periodic request wrong");
   pit_flag_a: assert property (pit_tick |=> pit_flag
      ##1 (irq_periodic || !$past(pit_en))) else $error("periodic flag or request missing");
   flag_clear_a: assert property (bus.wr && bus.addr == `RTCPIT_OFS_INTFLAG
      && bus.wdata[0] && !wrap |=> !int_flag[0]) else $error("overflow flag not cleared");
   match_clear_a: assert property (bus.wr && bus.addr == `RTCPIT_OFS_INTFLAG
      && bus.wdata[1] && !match |=> !int_flag[1]) else $error("compare flag not cleared");
   flag_keep_a: assert property (int_flag[0] && !(bus.wr
      && bus.addr == `RTCPIT_OFS_INTFLAG && bus.wdata[0]) |=> int_flag[0])
      else $error("overflow flag lost");
   pit_clear_a: assert property (bus.wr && bus.addr == `RTCPIT_OFS_PITFLAG
      && bus.wdata[0] && !pit_tick |=> !pit_flag) else $error("periodic flag not cleared");
   standby_stop_a: assert property (sleep_standby && !ctrl_act[`RTCPIT_STBY_BIT]
      |-> !cnt_tick) else $error("counter ran in standby");
   counter_off_a: assert property (!ctrl_act[`RTCPIT_EN_BIT] |-> !cnt_tick)
      else $error("disabled counter ticked");
   rsvd_source_a: assert property (clk_sel == RTCPIT_SRC_RSVD |-> !slow_tick)
      else $error("reserved source ticked");
   busy_set_a: assert property (wr_ctrl |=> busy[0] && !$past(apply))
      else $error("control busy not set");
   busy_hold_a: assert property (busy[2] && !apply |=> busy[2])
      else $error("limit busy dropped early");
   pit_busy_a: assert property (wr_pit |=> pit_busy) else $error("periodic busy not set");
   sync_delay_a: assert property (apply |-> slow_tick
      && wr_ticks == `RTCPIT_SYNC_TICKS - 2'h1) else $error("sync window length wrong");
   ctrl_apply_a: assert property (apply && busy[0] |=> ctrl_act == $past(ctrl_sw)
      && !busy[0]) else $error("control not applied");
   limit_apply_a: assert property (apply && busy[2] |=> per_act == $past(per_sw)
      && !busy[2]) else $error("limit not applied");
   match_apply_a: assert property (apply && busy[3] |=> cmp_act == $past(cmp_sw)
      && !busy[3]) else $error("compare not applied");
   pit_apply_a: assert property (apply && pit_busy |=> pit_act == $past(pit_sw)
      && !pit_busy) else $error("periodic control not applied");
   count_load_a: assert property (apply && busy[1] |=> cnt == $past(cnt_sw))
      else $error("count not loaded");
   wrap_zero_a: assert property (wrap && !(apply && busy[1]) |=> cnt == 16'h0000)
      else $error("counter did not wrap to zero");

   wrap_seen_c: cover property (wrap);
   match_seen_c: cover property (match);
   pit_seen_c: cover property (pit_tick);
   apply_seen_c: cover property (apply && busy[0]);
   ext_tick_c: cover property (clk_sel == RTCPIT_SRC_EXT && cnt_tick);
endmodule

/* File: verif/rtcpit_tb.sv */
// Self-checking bench for the real-time counter with periodic timer
module rtcpit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rtcpit_pkg::*;

   logic clk;
   logic rstn;
   rtcpit_bus_s bus;
   logic [7:0] rdata;
   logic osc_32768_hz = 1'b0;
   logic ext_pin = 1'b0;
   logic ext_run = 1'b0;
   logic sleep_standby;
   logic cpu_halted;
   logic irq_counter;
   logic irq_periodic;
   logic [3:0] osc_div = 4'h0;
   int n_fail;
   int samples_checked;
   int cycles = 0;

   rtcpit i_dut (
      .clk(clk),
      .rstn(rstn),
      .bus(bus),
      .rdata(rdata),
      .osc_32768_hz(osc_32768_hz),
      .external_clock_pin(ext_pin),
      .sleep_standby(sleep_standby),
      .cpu_halted(cpu_halted),
      .irq_counter(irq_counter),
      .irq_periodic(irq_periodic)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Slow source of 16 peripheral_clock period, well above the 4 clk half period needed
   always @(posedge clk) begin
      osc_div <= osc_div + 4'h1;
      osc_32768_hz <= osc_div[3];
      // Pin source: 8 clk period, stands still unless ext_run
      ext_pin <= ext_run & osc_div[2];
   end

   // Whole run is a few thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rdchk(input string name, input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(name, exp, d);
   endtask

   // Polls both busy registers so no synced write lands inside a window
   task automatic settle();
      logic [7:0] s;
      logic [7:0] p;
      for (int i = 0; i < 50; i++) begin
         rd(5'h01, s);
         rd(5'h11, p);
         if ((s | p) === 8'h00) break;
      end
      chk("sync idle", 8'h00, s | p);
   endtask

   initial begin
      rstn = 1'b0;
      bus = '0;
      sleep_standby = 1'b0;
      cpu_halted = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rdchk("control reset", 5'h00, 8'h00);
      rdchk("status reset", 5'h01, 8'h00);
      rdchk("limit low reset", 5'h0a, 8'hff);
      rdchk("limit high reset", 5'h0b, 8'h00);
      rdchk("unmapped", 5'h06, 8'h00);
      wr(5'h0a, 8'h05);
      rdchk("byte latch", 5'h04, 8'h05);
      wr(5'h0b, 8'h00);
      rdchk("limit busy", 5'h01, 8'h04);
      settle();
      wr(5'h0c, 8'h03);
      wr(5'h0d, 8'h00);
      rdchk("match busy", 5'h01, 8'h08);
      settle();
      wr(5'h08, 8'h00);
      wr(5'h09, 8'h00);
      rdchk("count busy", 5'h01, 8'h02);
      settle();
      wr(5'h02, 8'h03);
      wr(5'h00, 8'h01);
      rdchk("control busy", 5'h01, 8'h01);
      settle();
      repeat (200) @(posedge clk);
      wr(5'h00, 8'h00);
      settle();
      rdchk("flags after run", 5'h03, 8'h03);
      chk("irq counter", 8'h01, {7'h00, irq_counter});
      chk("irq periodic idle", 8'h00, {7'h00, irq_periodic});
      wr(5'h03, 8'h00);
      rdchk("flags write zero", 5'h03, 8'h03);
      wr(5'h03, 8'h01);
      rdchk("flags wrap clear", 5'h03, 8'h02);
      chk("irq counter held", 8'h01, {7'h00, irq_counter});
      wr(5'h02, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq counter masked", 8'h00, {7'h00, irq_counter});
      wr(5'h03, 8'h02);
      rdchk("flags cleared", 5'h03, 8'h00);
      // Count pair with the counter off, then back to zero for the runs below
      wr(5'h08, 8'h02);
      wr(5'h09, 8'h01);
      settle();
      rdchk("count low", 5'h08, 8'h02);
      rdchk("count high", 5'h09, 8'h01);
      wr(5'h08, 8'h00);
      wr(5'h09, 8'h00);
      settle();
      // Standby without keep-alive must freeze the count
      sleep_standby <= 1'b1;
      wr(5'h00, 8'h01);
      settle();
      repeat (200) @(posedge clk);
      rdchk("flags standby stop", 5'h03, 8'h00);
      wr(5'h00, 8'h81);
      settle();
      repeat (200) @(posedge clk);
      rdchk("flags standby run", 5'h03, 8'h03);
      chk("irq counter off", 8'h00, {7'h00, irq_counter});
      sleep_standby <= 1'b0;
      wr(5'h00, 8'h79);
      settle();
      wr(5'h03, 8'h03);
      repeat (200) @(posedge clk);
      rdchk("flags slow prescale", 5'h03, 8'h00);
      // Periodic timer keeps going in standby
      sleep_standby <= 1'b1;
      wr(5'h12, 8'h01);
      wr(5'h10, 8'h09);
      rdchk("periodic busy", 5'h11, 8'h01);
      settle();
      repeat (200) @(posedge clk);
      chk("irq periodic", 8'h01, {7'h00, irq_periodic});
      rdchk("periodic flag", 5'h13, 8'h01);
      wr(5'h10, 8'h00);
      settle();
      wr(5'h13, 8'h01);
      rdchk("periodic flag clr", 5'h13, 8'h00);
      chk("irq periodic clr", 8'h00, {7'h00, irq_periodic});
      // Pin source: sync runs on the oscillator first, since a still pin never applies
      sleep_standby <= 1'b0;
      wr(5'h00, 8'h01);
      settle();
      wr(5'h07, 8'h03);
      rdchk("clock source", 5'h07, 8'h03);
      wr(5'h03, 8'h03);
      repeat (200) @(posedge clk);
      rdchk("flags pin still", 5'h03, 8'h00);
      ext_run <= 1'b1;
      repeat (200) @(posedge clk);
      rdchk("flags pin clock", 5'h03, 8'h03);
      cpu_halted <= 1'b1;
      wr(5'h03, 8'h03);
      repeat (200) @(posedge clk);
      rdchk("flags halted", 5'h03, 8'h00);
      wr(5'h05, 8'h01);
      repeat (200) @(posedge clk);
      rdchk("flags halted run", 5'h03, 8'h03);
      cpu_halted <= 1'b0;
      wr(5'h07, 8'h02);
      wr(5'h03, 8'h03);
      repeat (200) @(posedge clk);
      rdchk("flags reserved source", 5'h03, 8'h00);
      final_report();
   end
endmodule
